// *** bench/srw_host_model.sv ***
// Host model: a bus master sending START, eight bits and STOP.
// Assumes pulled-up lines, so a released line reads high.
`timescale 1ns/100ps
module srw_host_model (
    input  wire logic       clk,
    input  wire logic       xfer_req,
    input  wire logic [7:0] xfer_byte,
    output logic            scl,
    output logic            sda,
    output logic            busy
);
    // Set both lines, then hold them eight cycles.
    task automatic step(input logic c, input logic d);
        scl = c;
        sda = d;
        repeat (8) @(negedge clk);
    endtask : step
    // Lines start idle and released.
    initial begin
        scl = 1'b1;
        sda = 1'b1;
        busy = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    // One framed byte; a request is taken only on an idle bus.
    always @(posedge clk) begin
        if (xfer_req && !busy) begin
            busy = 1'b1;
            @(negedge clk);
            step(1'b1, 1'b0);
            for (int i = 7; i >= 0; i--) begin
                step(1'b0, sda);
                step(1'b0, xfer_byte[i]);
                step(1'b1, xfer_byte[i]);
            end
            step(1'b0, 1'b0);
            step(1'b1, 1'b0);
            step(1'b1, 1'b1);
            busy = 1'b0;
        end
    end
endmodule : srw_host_model

// *** bench/srw_supervisor_chk.sv ***
// Port checker for the supervisory reset block, bound into it.
// Assumes the bench shortens both counts through the parameters.
`timescale 1ns/100ps
module srw_supervisor_chk #(
    parameter int unsigned HOLD_CYCLES = 50,
    parameter int unsigned WD_CYCLES   = 400
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic supply_ok_in,
    input wire logic manual_pushbutton_n_in,
    input wire logic write_protect_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic reset_n_o,
    input wire logic reset_n_oe,
    input wire logic reset_o,
    input wire logic reset_oe,
    input wire logic mem_enable_o,
    input wire logic write_allow_o,
    input wire logic bus_start_o,
    input wire logic bus_stop_o,
    input wire logic bus_selected_o
);
    int unsigned hi_r, hi_nxt, idle_r, idle_nxt;
    logic        sda_r;
    // Count cycles in reset and cycles with a quiet data line.
    always_comb begin
        hi_nxt = (rst_n && reset_n_oe) ? hi_r + 32'h1 : 32'h0;
        idle_nxt = (!rst_n || reset_n_oe || sda_in != sda_r) ?
                   32'h0 : idle_r + 32'h1;
    end
    // Register the helper counters.
    always_ff @(posedge clk) begin
        hi_r <= hi_nxt;
        idle_r <= idle_nxt;
        sda_r <= sda_in;
    end
    ////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    oe_pair_a: assert property (reset_n_oe == reset_oe)
        else $error("reset pin enables disagree");
    drive_level_a: assert property (
        reset_n_oe |-> !reset_n_o && reset_o)
        else $error("reset pin driven to inactive level");
    hold_len_a: assert property (
        $fell(reset_n_oe) |-> hi_r >= HOLD_CYCLES)
        else $error("reset released before hold interval");
    pb_react_a: assert property (
        !manual_pushbutton_n_in [*8] |-> ##[0:17] reset_n_oe)
        else $error("pushbutton did not reset in time");
    trip_react_a: assert property (
        !supply_ok_in [*3] |-> ##[0:120] reset_n_oe)
        else $error("supply drop did not reset in time");
    wp_block_a: assert property (
        write_protect_in [*6] |-> !write_allow_o)
        else $error("write allowed while protected");
    mem_off_a: assert property (
        reset_n_oe [*3] |-> !mem_enable_o && !bus_selected_o)
        else $error("memory active during reset");
    wd_fire_a: assert property (
        idle_r == WD_CYCLES + 32'ha |-> reset_n_oe)
        else $error("watchdog did not expire");
    start_seen_a: assert property (
        bus_start_o |-> scl_in && !sda_in ##1 !bus_start_o)
        else $error("bad start pulse");
    stop_seen_a: assert property (bus_stop_o |-> scl_in && sda_in)
        else $error("stop pulse without stop condition");
endmodule : srw_supervisor_chk
bind srw_supervisor srw_supervisor_chk #(.HOLD_CYCLES(HOLD_CYCLES),
    .WD_CYCLES(WD_CYCLES)) u_chk (.*);

// *** bench/test_supervisor_reset_watchdog.sv ***
// Self-checking bench for the supervisory reset block.
// Assumes a pull-up on the reset pin and the host model on the bus.
`timescale 1ns/100ps
module test_supervisor_reset_watchdog;
    localparam int unsigned HOLD = 50;
    localparam int unsigned WDC  = 400;
    logic clk = 1'b0, rst_n = 1'b0, sup = 1'b0, pb = 1'b1, pin_drv = 1'b1;
    logic kick = 1'b0, wp = 1'b0, wbusy = 1'b0, req = 1'b0;
    logic [7:0] byt = 8'h00;
    logic scl, sda, mbusy, rn_o, rn_oe, r_o, r_oe, men, wal, bst, bsp, bsel;
    int miscompares = 0;
    int compares = 0;
    int nst = 0;
    int nsp = 0;
    // Reset pin wire: pulled up, low when either party pulls it.
    wire logic pin_n = pin_drv & ~(rn_oe & ~rn_o);
    always #20 clk = ~clk;
    // Counts start and stop pulses; each pulse stands over one negedge.
    always @(negedge clk) begin
        nst <= nst + int'(bst === 1'b1);
        nsp <= nsp + int'(bsp === 1'b1);
    end
    srw_supervisor #(.HOLD_CYCLES(HOLD), .WD_CYCLES(WDC), .WD_ON_KICK(1'b0))
    uut (.clk(clk), .rst_n(rst_n), .supply_ok_in(sup),
        .manual_pushbutton_n_in(pb), .reset_pin_n_in(pin_n),
        .watchdog_kick_in(kick), .write_protect_in(wp), .scl_in(scl),
        .sda_in(sda), .write_busy_in(wbusy), .reset_n_o(rn_o),
        .reset_n_oe(rn_oe), .reset_o(r_o), .reset_oe(r_oe),
        .mem_enable_o(men), .write_allow_o(wal), .bus_start_o(bst),
        .bus_stop_o(bsp), .bus_selected_o(bsel));
    srw_host_model host (.clk(clk), .xfer_req(req), .xfer_byte(byt),
        .scl(scl), .sda(sda), .busy(mbusy));
    ////////////////////////////////////////////////////////////
    function automatic logic exp_wal(input logic p, input logic b);
        return ~p & ~b;
    endfunction : exp_wal
    task automatic nc(input int n);
        repeat (n) @(negedge clk);
    endtask : nc
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Waits out a reset and checks how long it stood.
    task automatic rel(input int lo, input int hi);
        int n;
        n = 0;
        while (rn_oe === 1'b1 && n < hi + 5) begin
            nc(1);
            n++;
        end
        chk(8'(n >= lo && n <= hi), 8'h01);
        nc(2);
    endtask : rel
    // Waits for a reset to begin and checks how long that took.
    task automatic rise(input int lo, input int hi);
        int n;
        n = 0;
        while (rn_oe !== 1'b1 && n < hi + 5) begin
            nc(1);
            n++;
        end
        chk(8'(n >= lo && n <= hi), 8'h01);
    endtask : rise
    task automatic xfer(input logic [7:0] b);
        byt = b;
        req = 1'b1;
        nc(1);
        req = 1'b0;
    endtask : xfer
    task automatic results();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results
    // Stops a hang long after the sequence should end.
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        results();
    end
    // Main sequence of scenarios.
    initial begin
        void'($urandom(32'ha303));
        nc(20);
        rst_n = 1'b1;
        nc(10);
        chk(8'({rn_oe, r_oe, men}), 8'h06);
        sup = 1'b1;
        rel(HOLD, HOLD + 12);
        chk(8'({rn_oe, r_oe, men}), 8'h01);
        for (int i = 0; i < 6; i++) begin
            wp = 1'($urandom);
            wbusy = 1'($urandom);
            kick = ~kick;
            nc(6);
            chk(8'(wal), 8'(exp_wal(wp, wbusy)));
        end
        sup = 1'b0;
        nc(1);
        sup = 1'b1;
        nc(12);
        chk(8'(rn_oe), 8'h00);
        pb = 1'b0;
        nc(2);
        pb = 1'b1;
        nc(12);
        chk(8'(rn_oe), 8'h00);
        xfer(8'($urandom));
        nc(30);
        chk(8'(bsel), 8'h01);
        while (mbusy) nc(1);
        nc(8);
        chk(8'(bsel), 8'h00);
        chk(8'(nst), 8'h01);
        chk(8'(nsp), 8'h01);
        xfer(8'($urandom));
        nc(30);
        pb = 1'b0;
        nc(25);
        chk(8'({rn_oe, men, bsel}), 8'h04);
        nc(WDC + $urandom % 50);
        pb = 1'b1;
        rel(HOLD, HOLD + 12);
        nc(WDC - 60);
        chk(8'(rn_oe), 8'h00);
        pin_drv = 1'b0;
        nc(2);
        pin_drv = 1'b1;
        nc(10);
        chk(8'(rn_oe), 8'h01);
        rel(HOLD - 12, HOLD + 12);
        sup = 1'b0;
        nc(120);
        chk(8'(rn_oe), 8'h01);
        nc($urandom % 40);
        sup = 1'b1;
        rel(HOLD, HOLD + 12);
        nc(WDC - 40);
        xfer(8'h00);
        while (mbusy) nc(1);
        nc(WDC - 40);
        chk(8'(rn_oe), 8'h00);
        rise(28, 42);
        chk(8'(rn_oe), 8'h01);
        rel(HOLD, HOLD + 12);
        results();
    end
endmodule : test_supervisor_reset_watchdog

// *** rtl/srw_pkg.sv ***
// Constants and carrier types for the supervisory reset and watchdog block.
// Assumes a 25 MHz free-running oscillator clock feeds the block.
package srw_pkg;

    // Clock rate in kHz and time figures in their own units.
    localparam int unsigned CLK_KHZ             = 25000;
    localparam int unsigned HOLD_TYP_MS         = 200;
    localparam int unsigned HOLD_MIN_MS         = 130;
    localparam int unsigned HOLD_MAX_MS         = 270;
    localparam int unsigned WD_TYP_MS           = 1600;
    localparam int unsigned WD_MIN_MS           = 1000;
    localparam int unsigned WD_MAX_MS           = 2100;
    localparam int unsigned TRIP_DELAY_NS       = 5000;
    localparam int unsigned GLITCH_NS           = 30;
    localparam int unsigned PB_GLITCH_NS        = 100;
    localparam int unsigned PB_MIN_PULSE_NS     = 5000;
    localparam int unsigned PB_OUT_DELAY_NS     = 1000;
    localparam int unsigned WRITE_CYCLE_MS      = 5;
    localparam int unsigned CLK_NS              = 40;

    // Derived cycle counts.
    localparam int unsigned HOLD_CYC  = HOLD_TYP_MS * (CLK_KHZ);
    localparam int unsigned WD_CYC    = WD_TYP_MS * (CLK_KHZ);
    // Supply filter: low must persist longer than the glitch width.
    localparam int unsigned SUP_FILT_CYC = GLITCH_NS / CLK_NS + 1;
    // Pushbutton filter: longer than glitch, well inside output delay.
    localparam int unsigned PB_FILT_CYC  =
        (PB_GLITCH_NS + CLK_NS - 1) / CLK_NS + 1;
    localparam int unsigned FILT_W   = 4;
    localparam int unsigned HOLD_W   = 23;
    localparam int unsigned WD_W     = 26;

    // Reset state machine.
    typedef enum logic [1:0] {
        SRW_ST_ACTIVE  = 2'b00,
        SRW_ST_STRETCH = 2'b01,
        SRW_ST_RUN     = 2'b10
    } srw_state_e;

    // Open-drain pin pair.
    typedef struct packed {
        logic o;
        logic oe;
    } srw_od_s;

    // Serial bus conditions seen on the pins.
    typedef struct packed {
        logic start;
        logic stop;
    } srw_bus_ev_s;

endpackage : srw_pkg

// *** rtl/srw_supervisor.sv ***
// Supervisory reset sequencer with pushbutton, reset-pin input and watchdog.
// Assumes all pin inputs are asynchronous to clk; the memory core that
// consumes the enable and bus conditions sits outside this module.
// Notes on behaviour
// - Hold resets active while supply low, then about 200 ms more.
// - After the hold interval, stop driving reset pins; pulls settle them.
// - Both reset pins are open drain, driven only when active.
// - Supply falling below trip asserts reset within 5 us.
// - Supply dips of 30 ns or shorter cause no reset.
// - Reset pin is also an input; its falling edge starts a reset.
// - External reset pin pulse yields at least 200 ms of reset.
// - Reset holds while pushbutton low, then for the full hold interval.
// - Pushbutton lows under 100 ns ignored; 5 us lows always reset.
// - Reset outputs activate within 1 us of pushbutton going low.
// - During reset the memory is disabled and bus transfers aborted.
// - No new write cycle starts in reset; a running one completes.
// - Write-protect input high disables all memory writes.
// - No toggle on monitored line for about 1.6 s forces reset.
// - Monitored line is the bus data line or the kick pin.
// - Any edge on the monitored line restarts the watchdog.
// - Watchdog counter held clear while reset is asserted.
// - START is data falling while clock high; respond only after START.
// - Data change during clock high is taken as START or STOP.
`timescale 1ns/100ps
module srw_supervisor #(
    parameter int unsigned HOLD_CYCLES = srw_pkg::HOLD_CYC,
    parameter int unsigned WD_CYCLES   = srw_pkg::WD_CYC,
    parameter bit          WD_ON_KICK  = 1'b0
) (
    input  wire logic  clk,
    input  wire logic  rst_n,
    input  wire logic  supply_ok_in,
    input  wire logic  manual_pushbutton_n_in,
    input  wire logic  reset_pin_n_in,
    input  wire logic  watchdog_kick_in,
    input  wire logic  write_protect_in,
    input  wire logic  scl_in,
    input  wire logic  sda_in,
    input  wire logic  write_busy_in,
    output logic       reset_n_o,
    output logic       reset_n_oe,
    output logic       reset_o,
    output logic       reset_oe,
    output logic       mem_enable_o,
    output logic       write_allow_o,
    output logic       bus_start_o,
    output logic       bus_stop_o,
    output logic       bus_selected_o
);

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers for every asynchronous input. The first stage
    // may go metastable, so only the second stage is read by any logic. In
    // reset the chain is loaded with the idle level of each pin, so no false
    // edge or false pushbutton low is seen when reset lets go. The supply
    // bit idles low on purpose: a device held in reset behaves as if the
    // supply had not yet reached the trip level.
    localparam int NSYNC = 7;
    // Idle levels in the order {supply, button, pin, kick, wp, scl, sda}.
    localparam logic [NSYNC-1:0] SYNC_IDLE = 7'h33;
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] s1_r;
    logic [NSYNC-1:0] s2_r;
    logic [NSYNC-1:0] s1_nxt;
    logic [NSYNC-1:0] s2_nxt;
    assign raw = {supply_ok_in, manual_pushbutton_n_in, reset_pin_n_in,
                  watchdog_kick_in, write_protect_in, scl_in, sda_in};

    // Next values of the synchroniser chain; idle levels on reset.
    always_comb begin
        s1_nxt = rst_n ? raw : SYNC_IDLE;
        s2_nxt = rst_n ? s1_r : SYNC_IDLE;
    end

    // Register the synchroniser chain.
    always_ff @(posedge clk) begin
        s1_r <= s1_nxt;
        s2_r <= s2_nxt;
    end

    logic sup_s;
    logic pb_s;
    logic pin_s;
    logic kick_s;
    logic wp_s;
    logic scl_s;
    logic sda_s;
    assign {sup_s, pb_s, pin_s, kick_s, wp_s, scl_s, sda_s} = s2_r;

    ////////////////////////////////////////////////////////////////////////
    // Low-level filters on supply and pushbutton, and edge history.
    // A supply low counts once it is seen on two samples in a row, so a
    // dip of one clock or less never starts a reset. The pushbutton must
    // stay low for five samples, about 200 ns, which rejects short glitches
    // while the whole path from pin to reset output stays well inside 1 us.
    // The edge history registers feed the pin, watchdog and bus detectors.
    logic [srw_pkg::FILT_W-1:0] sup_cnt_r;
    logic [srw_pkg::FILT_W-1:0] sup_cnt_nxt;
    logic [srw_pkg::FILT_W-1:0] pb_cnt_r;
    logic [srw_pkg::FILT_W-1:0] pb_cnt_nxt;
    logic                       sup_low_r;
    logic                       sup_low_nxt;
    logic                       pb_low_r;
    logic                       pb_low_nxt;
    logic                       pin_d_r;
    logic                       pin_d_nxt;
    logic                       mon_d_r;
    logic                       mon_d_nxt;
    logic                       scl_d_r;
    logic                       scl_d_nxt;
    logic                       sda_d_r;
    logic                       sda_d_nxt;
    logic                       mon_s;
    logic                       pin_fall;
    logic                       mon_edge;
    // Monitored line select, reset pin fall and watchdog edge. The reset pin
    // is heard only while the device leaves it free, so that its own drive
    // never reads back as an external press.
    assign mon_s    = WD_ON_KICK ? kick_s : sda_s;
    assign pin_fall = pin_d_r & ~pin_s & reset_n_oe == 1'b0;
    assign mon_edge = mon_d_r ^ mon_s;

    localparam logic [srw_pkg::FILT_W-1:0] SUP_N =
        srw_pkg::FILT_W'(srw_pkg::SUP_FILT_CYC);
    localparam logic [srw_pkg::FILT_W-1:0] PB_N =
        srw_pkg::FILT_W'(srw_pkg::PB_FILT_CYC);

    // Filter counters: a low must persist for N+1 cycles to count. Each
    // counter saturates at its threshold, so a long press cannot wrap it
    // back into the quiet range.
    always_comb begin
        sup_cnt_nxt = sup_s ? '0 :
            (sup_cnt_r == SUP_N ? sup_cnt_r : sup_cnt_r + 1'b1);
        sup_low_nxt = ~sup_s & (sup_cnt_r == SUP_N);
        pb_cnt_nxt  = pb_s ? '0 :
            (pb_cnt_r == PB_N ? pb_cnt_r : pb_cnt_r + 1'b1);
        pb_low_nxt  = ~pb_s & (pb_cnt_r == PB_N);
        pin_d_nxt   = pin_s;
        mon_d_nxt   = mon_s;
        scl_d_nxt   = scl_s;
        sda_d_nxt   = sda_s;
        if (!rst_n) begin
            sup_cnt_nxt = '0;
            sup_low_nxt = 1'b1;
            pb_cnt_nxt  = '0;
            pb_low_nxt  = 1'b0;
            pin_d_nxt   = 1'b1;
            mon_d_nxt   = ~WD_ON_KICK;
            scl_d_nxt   = 1'b1;
            sda_d_nxt   = 1'b1;
        end
    end

    // Register the filters and edge history; reset is synchronous and
    // reaches these registers through the next-value logic above.
    always_ff @(posedge clk) begin
        sup_cnt_r <= sup_cnt_nxt;
        sup_low_r <= sup_low_nxt;
        pb_cnt_r  <= pb_cnt_nxt;
        pb_low_r  <= pb_low_nxt;
        pin_d_r   <= pin_d_nxt;
        mon_d_r   <= mon_d_nxt;
        scl_d_r   <= scl_d_nxt;
        sda_d_r   <= sda_d_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset state machine with hold and watchdog counters.
    // ACTIVE holds reset for as long as a level cause (supply low or the
    // pushbutton) stands. STRETCH counts out the hold interval, and any
    // level cause during it starts over from ACTIVE. RUN releases the
    // outputs and lets the watchdog count; a falling edge on the reset pin
    // or a watchdog expiry sends the machine back to STRETCH, so those
    // causes get one full hold interval however short they were.
    srw_pkg::srw_state_e         st_r;
    srw_pkg::srw_state_e         st_nxt;
    logic [srw_pkg::HOLD_W-1:0]  hold_r;
    logic [srw_pkg::HOLD_W-1:0]  hold_nxt;
    logic [srw_pkg::WD_W-1:0]    wd_r;
    logic [srw_pkg::WD_W-1:0]    wd_nxt;
    logic                        force_rst;
    logic                        wd_expire;
    localparam logic [srw_pkg::HOLD_W-1:0] HOLD_END =
        srw_pkg::HOLD_W'(HOLD_CYCLES - 1);
    localparam logic [srw_pkg::WD_W-1:0] WD_END =
        srw_pkg::WD_W'(WD_CYCLES - 1);
    // Level causes force ACTIVE; the watchdog expires on its last count.
    assign force_rst = sup_low_r | pb_low_r;
    assign wd_expire = (st_r == srw_pkg::SRW_ST_RUN) & (wd_r == WD_END);

    // Next state: level causes hold ACTIVE; edges and expiry restart hold.
    // The watchdog counter is cleared in every state but RUN, so a reset
    // of any cause leaves it at zero and the host gets a full interval
    // after each release before it must show activity on the line.
    always_comb begin
        st_nxt   = st_r;
        hold_nxt = hold_r;
        wd_nxt   = '0;
        unique case (st_r)
            srw_pkg::SRW_ST_ACTIVE: begin
                hold_nxt = '0;
                if (!force_rst) begin
                    st_nxt = srw_pkg::SRW_ST_STRETCH;
                end
            end
            srw_pkg::SRW_ST_STRETCH: begin
                hold_nxt = hold_r + 1'b1;
                if (hold_r == HOLD_END) begin
                    st_nxt = srw_pkg::SRW_ST_RUN;
                end
            end
            srw_pkg::SRW_ST_RUN: begin
                hold_nxt = '0;
                wd_nxt = mon_edge ? '0 : wd_r + 1'b1;
                if (pin_fall || wd_expire) begin
                    st_nxt = srw_pkg::SRW_ST_STRETCH;
                end
            end
            default: begin
                st_nxt = srw_pkg::SRW_ST_ACTIVE;
            end
        endcase
        if (force_rst) begin
            st_nxt   = srw_pkg::SRW_ST_ACTIVE;
            hold_nxt = '0;
        end
        if (st_nxt != srw_pkg::SRW_ST_RUN) begin
            wd_nxt = '0;
        end
        if (!rst_n) begin
            st_nxt   = srw_pkg::SRW_ST_ACTIVE;
            hold_nxt = '0;
            wd_nxt   = '0;
        end
    end

    // Register the reset state and counters.
    // The counters are wide enough for the full-length intervals.
    always_ff @(posedge clk) begin
        st_r   <= st_nxt;
        hold_r <= hold_nxt;
        wd_r   <= wd_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus condition detector and output registers.
    // Start and stop are judged on synchronised samples one cycle apart,
    // so a data change seen while the clock line is high on both samples
    // is a condition and never a data bit. The selected flag follows the
    // bus from a start to the next stop and is dropped by any reset, which
    // aborts a transfer in progress and refuses new ones until release.
    logic in_rst_nxt;
    logic start_nxt;
    logic stop_nxt;
    logic sel_nxt;
    assign in_rst_nxt = (st_nxt != srw_pkg::SRW_ST_RUN);

    // Next values of the bus conditions and the selected flag. A start and
    // a stop cannot fall in one cycle, since each needs the data line to
    // move the other way.
    always_comb begin
        start_nxt = scl_d_r & scl_s & sda_d_r & ~sda_s;
        stop_nxt  = scl_d_r & scl_s & ~sda_d_r & sda_s;
        sel_nxt   = bus_selected_o;
        if (start_nxt) begin
            sel_nxt = 1'b1;
        end else if (stop_nxt) begin
            sel_nxt = 1'b0;
        end
        if (in_rst_nxt) begin
            sel_nxt = 1'b0;
        end
        if (!rst_n) begin
            start_nxt = 1'b0;
            stop_nxt  = 1'b0;
            sel_nxt   = 1'b0;
        end
    end

    // Register all outputs; active reset is driven, released is tristated.
    // Both reset pins are open drain: the drive level is a constant and
    // only the enable moves, so a released pin is left to its resistor.
    // Write permission also waits out a running internal write, which is
    // never cut short; it only stops a new write from being started.
    always_ff @(posedge clk) begin
        reset_n_o      <= 1'b0;
        reset_n_oe     <= in_rst_nxt | ~rst_n;
        reset_o        <= 1'b1;
        reset_oe       <= in_rst_nxt | ~rst_n;
        mem_enable_o   <= ~in_rst_nxt & rst_n;
        write_allow_o  <= ~in_rst_nxt & rst_n & ~wp_s
                          & ~write_busy_in;
        bus_start_o    <= start_nxt;
        bus_stop_o     <= stop_nxt;
        bus_selected_o <= sel_nxt;
    end

endmodule : srw_supervisor
